// *** logic/hmirq_pkg.sv ***
// constants for the health monitor event and interrupt-enable block
package hmirq_pkg;
    // register offsets on the host register path
    localparam logic [7:0] HMIRQ_OFS_EVT1 = 8'h03;
    localparam logic [7:0] HMIRQ_OFS_EVT2 = 8'h04;
    localparam logic [7:0] HMIRQ_OFS_EN1  = 8'h05;
    localparam logic [7:0] HMIRQ_OFS_EN2  = 8'h06;
    // reset values
    localparam logic [7:0] HMIRQ_RST_EVT1 = 8'h00;
    localparam logic [7:0] HMIRQ_RST_EVT2 = 8'h00;
    localparam logic [7:0] HMIRQ_RST_EN1  = 8'h00;
    localparam logic [7:0] HMIRQ_RST_EN2  = 8'h00;
    // implemented bits: bit 7 of the first pair is reserved, reads zero
    localparam logic [7:0] HMIRQ_MASK1    = 8'h7f;
    localparam logic [7:0] HMIRQ_MASK2    = 8'hff;
    // field positions in the second event and enable registers
    localparam int HMIRQ_B_SEC_SENS  = 7;
    localparam int HMIRQ_B_RDIODE    = 6;
    localparam int HMIRQ_B_FAN_HI    = 5;
    localparam int HMIRQ_B_FAN_LO    = 2;
    localparam int HMIRQ_B_PRI_SENS  = 1;
    localparam int HMIRQ_B_TWELVE    = 0;
    // field positions in the first event and enable registers
    localparam int HMIRQ_B_ZONE_HI   = 6;
    localparam int HMIRQ_B_ZONE_LO   = 4;
    localparam int HMIRQ_B_FIVE      = 3;
    localparam int HMIRQ_B_THREE3    = 2;
    localparam int HMIRQ_B_CORE      = 1;
    localparam int HMIRQ_B_TWO5      = 0;

    // whole register state
    typedef struct packed {
        logic [7:0] event_status_first;
        logic [7:0] event_status_second;
        logic [7:0] irq_enable_first;
        logic [7:0] irq_enable_second;
        logic [7:0] rdata;
        logic       irq;
    } hmirq_state_t;
endpackage

// *** logic/hmirq_top.sv ***
// event latching, enables and interrupt request for the health monitor
`timescale 1ns/100ps

// Behaviour
// - second event register at 04h, 8 bits, reset zero, write one clears.
// - bit 7 latches secondary sensor communication events until cleared.
// - bit 6 latches remote diode physical connection events.
// - bits 5..2 latch fan tachometer 4..1 state changes.
// - bit 1 latches primary sensor communication events.
// - bit 0 latches 12 volt state changes.
// - first enable register at 05h, read/write, reset zero, bit 7 reserved.
// - first enable bits 6..0 gate zones 3..1, 5V, 3.3V, core, 2.5V events.
// - second enable register at 06h, read/write, reset zero, one per event.
// - second enable bit n gates second event bit n.
// - enable zero suppresses the request; the event still latches.
// - first event register at 03h, bits 6..0, write one clears.
module hmirq_top
    import hmirq_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // register access port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // one-cycle event pulses from the monitoring engine
    input  wire logic [6:0] first_events_i,
    input  wire logic       secondary_sensor_comm_event_i,
    input  wire logic       remote_diode_fault_event_i,
    input  wire logic [3:0] fan_events_i,
    input  wire logic       primary_sensor_comm_event_i,
    input  wire logic       twelve_volt_event_i,
    // event register views and interrupt request
    output logic      [7:0] event_status_first_o,
    output logic      [7:0] event_status_second_o,
    output logic            irq_o
);

    hmirq_state_t st;
    hmirq_state_t next_st;
    logic [7:0]   set1;
    logic [7:0]   set2;

    // w1c update: hardware set beats a software clear in the same cycle
    function automatic logic [7:0] w1c_update(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic [7:0] clr,
        input logic [7:0] mask
    );
        w1c_update = ((cur & ~clr) | set) & mask;
    endfunction

    // collect raw event inputs into register bit order
    always_comb begin
        set1 = {1'b0, first_events_i};
        set2 = 8'h00;
        set2[HMIRQ_B_SEC_SENS] = secondary_sensor_comm_event_i;
        set2[HMIRQ_B_RDIODE]   = remote_diode_fault_event_i;
        set2[HMIRQ_B_FAN_HI:HMIRQ_B_FAN_LO] = fan_events_i;
        set2[HMIRQ_B_PRI_SENS] = primary_sensor_comm_event_i;
        set2[HMIRQ_B_TWELVE]   = twelve_volt_event_i;
    end

    // next-state: register writes, event latching, read data, request
    always_comb begin
        logic [7:0] clr1;
        logic [7:0] clr2;
        clr1 = 8'h00;
        clr2 = 8'h00;
        next_st = st;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                HMIRQ_OFS_EVT1: clr1 = reg_wdata_i;
                HMIRQ_OFS_EVT2: clr2 = reg_wdata_i;
                HMIRQ_OFS_EN1: begin
                    // reserved bit 7 is not stored
                    next_st.irq_enable_first =
                        reg_wdata_i & HMIRQ_MASK1;
                end
                HMIRQ_OFS_EN2: begin
                    next_st.irq_enable_second =
                        reg_wdata_i & HMIRQ_MASK2;
                end
                default: begin
                    // writes elsewhere are ignored
                end
            endcase
        end
        // latching ignores the enables entirely
        next_st.event_status_first = w1c_update(st.event_status_first,
            set1, clr1, HMIRQ_MASK1);
        next_st.event_status_second = w1c_update(st.event_status_second,
            set2, clr2, HMIRQ_MASK2);
        // read data is registered, so it shows one cycle after the strobe
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                HMIRQ_OFS_EVT1: next_st.rdata = st.event_status_first;
                HMIRQ_OFS_EVT2: next_st.rdata = st.event_status_second;
                HMIRQ_OFS_EN1:  next_st.rdata = st.irq_enable_first;
                HMIRQ_OFS_EN2:  next_st.rdata = st.irq_enable_second;
                default:        next_st.rdata = 8'h00;
            endcase
        end
        // request from the new values so it tracks the registers exactly
        next_st.irq =
            |(next_st.event_status_first & next_st.irq_enable_first) |
            |(next_st.event_status_second &
              next_st.irq_enable_second);
    end

    // state register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st.event_status_first  <= HMIRQ_RST_EVT1;
            st.event_status_second <= HMIRQ_RST_EVT2;
            st.irq_enable_first    <= HMIRQ_RST_EN1;
            st.irq_enable_second   <= HMIRQ_RST_EN2;
            st.rdata               <= 8'h00;
            st.irq                 <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign reg_rdata_o           = st.rdata;
    assign event_status_first_o  = st.event_status_first;
    assign event_status_second_o = st.event_status_second;
    assign irq_o                 = st.irq;

endmodule

// *** verif/hmirq_assertions.sv ***
// checker on the event block's ports
`timescale 1ns/100ps
module hmirq_checker (
    // clock, reset and register port
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // events, status views and request
    input wire logic [3:0] fan_events_i,
    input wire logic       twelve_volt_event_i,
    input wire logic [7:0] event_status_first_o,
    input wire logic [7:0] event_status_second_o,
    input wire logic       irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    fan_set_a: assert property (
        fan_events_i[0] |=> event_status_second_o[2])
        else $error("fan event lost");
    volt_set_a: assert property (twelve_volt_event_i |=>
        event_status_second_o[0]) else $error("12V event lost");
    bits_sticky_a: assert property (
        !reg_wr_i |=> (event_status_second_o &
        $past(event_status_second_o)) == $past(event_status_second_o))
        else $error("event bit dropped");
    write_clear_a: assert property (reg_wr_i && reg_addr_i == 8'h04 &&
        reg_wdata_i[2] && !fan_events_i[0] |=> !event_status_second_o[2])
        else $error("write one did not clear");
    read_status_a: assert property (reg_rd_i && reg_addr_i == 8'h04 |=>
        reg_rdata_o == $past(event_status_second_o)) else $error("bad read");
    irq_cause_a: assert property (irq_o |->
        (event_status_first_o | event_status_second_o) != 8'h00)
        else $error("request without event");
    enable_rsv_a: assert property (reg_rd_i && reg_addr_i == 8'h05 |=>
        !reg_rdata_o[7]) else $error("reserved enable bit set");
    first_rsv_a: assert property (!event_status_first_o[7])
        else $error("reserved event bit set");
    cover property (irq_o);
    cover property ($fell(irq_o));
    cover property (reg_wr_i && reg_addr_i == 8'h04 && fan_events_i[0]);
endmodule
bind hmirq_top hmirq_checker chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .fan_events_i(fan_events_i), .twelve_volt_event_i(twelve_volt_event_i),
    .event_status_first_o(event_status_first_o),
    .event_status_second_o(event_status_second_o));

// *** verif/hmirq_host.sv ***
// host interrupt controller model: counts request assertions
`timescale 1ns/100ps
module hmirq_host (
    // level request in, count of raised requests out
    input  wire logic       irq_i,
    output logic      [7:0] raised_o
);
    // a level request is taken once, at its rise
    initial raised_o = 8'h00;
    always @(posedge irq_i) raised_o <= raised_o + 8'h01;
endmodule

// *** verif/hmirq_top_test.sv ***
// self-checking bench for the event block
`timescale 1ns/100ps
module hmirq_top_test;
    logic       clk_i = 0, arst_n_i = 0, wr = 0, rd = 0, irq;
    logic [7:0] addr = 0, wd = 0, ev2 = 0, rdata, st1, st2, raised;
    logic [6:0] ev1 = 0;
    int         miscompares = 0, check_count = 0, cycles = 0;
    always #25 clk_i = ~clk_i;
    hmirq_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .first_events_i(ev1), .secondary_sensor_comm_event_i(ev2[7]),
        .remote_diode_fault_event_i(ev2[6]), .fan_events_i(ev2[5:2]),
        .primary_sensor_comm_event_i(ev2[1]), .twelve_volt_event_i(ev2[0]),
        .event_status_first_o(st1), .event_status_second_o(st2), .irq_o(irq));
    hmirq_host host_u (.irq_i(irq), .raised_o(raised));
    task automatic chk(input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes and event pulses, launched at the falling edge
    task automatic acc(input logic w, r, input logic [7:0] a, d, e1, e2);
        @(negedge clk_i);
        {wr, rd, addr, wd, ev1, ev2} = {w, r, a, d, e1[6:0], e2};
        @(negedge clk_i);
        {wr, rd, ev1, ev2} = '0;
    endtask
    task automatic t_regs;
        acc(0, 1, 8'h04, 0, 0, 0); chk(rdata, 0);
        acc(0, 1, 8'h06, 0, 0, 0); chk(rdata, 0);
        acc(1, 0, 8'h05, 8'hff, 0, 0);
        acc(0, 1, 8'h05, 0, 0, 0); chk(rdata, 16'h007f);
    endtask
    // enable off still latches; enable on raises; write one clears
    task automatic t_second;
        for (int i = 0; i < 8; i++) begin
            acc(0, 0, 0, 0, 0, 8'h01 << i);
            chk({st2, 7'h0, irq}, {8'h01 << i, 8'h00});
            acc(1, 0, 8'h06, 8'h01 << i, 0, 0);
            chk({st2, 7'h0, irq}, {8'h01 << i, 8'h01});
            acc(1, 0, 8'h04, 8'h01 << i, 0, 0);
            chk({st2, 7'h0, irq}, 16'h0000);
        end
        // the bit must already be pending, or the race proves nothing
        acc(0, 0, 0, 0, 0, 8'h04);
        chk({8'h00, st2}, 16'h0004);
        acc(1, 0, 8'h04, 8'h04, 0, 8'h04); // clear racing a new fan event
        chk({st2, 7'h0, irq}, 16'h0400);
        acc(1, 0, 8'h04, 8'hff, 0, 0);
    endtask
    task automatic t_first;
        for (int i = 0; i < 7; i++) begin
            acc(1, 0, 8'h05, 0, 0, 0);
            acc(0, 0, 0, 0, 8'h01 << i, 0);
            chk({st1, 7'h0, irq}, {8'h01 << i, 8'h00});
            acc(1, 0, 8'h05, 8'h01 << i, 0, 0);
            chk({st1, 7'h0, irq}, {8'h01 << i, 8'h01});
            acc(1, 0, 8'h03, 8'hff, 0, 0);
            chk({st1, st2}, 16'h0000);
        end
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        arst_n_i = 1;
        t_regs;
        t_second;
        t_first;
        chk({8'h00, raised}, 16'h000f);
        give_verdict;
    end
    // hang guard, well above the roughly 140 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict;
        end
    end
endmodule
